// file: pnpc_defines.vh
// pnpc_defines.vh: constants of the plug-and-play configuration block.
// assumes inclusion by bare name from the block's design file only.
//
// Overview of operation
// - ecp modes align parallel base to eight bytes
// - spp mode decodes base to base plus 02h
// - epp mode decodes eight registers from base
// - mode 1000 decodes six registers, two groups
// - mode 1110 decodes eleven registers, two groups
// - mode four with bit4 decodes sixteen registers
// - no parallel response outside decoded range
// - base address bits 15-11 read zero
// - index 00h loads read port bits 9-2
// - index 01h reads compare one id bit
// - command register write-only, bits self-clear
// - bit0 resets devices except keyboard, keeps csn
// - bit1 returns to wait-for-key, not motherboard
// - bit2 clears card select number
// - matching wake enters isolation or config
// - index 04h gives next resource byte
// - status bit0 flags resource byte ready
// - index 06h holds card select number
// - index 07h selects current logical device
// - device commands reach selected device only
// - index port reads back in motherboard mode, data port reads indexed
// - strap low waits for key, high enters config
`ifndef PNPC_DEFINES_VH
`define PNPC_DEFINES_VH
// -------------------------------------------------
// register indexes
// -------------------------------------------------
`define PNPC_IX_RDPORT   8'h00
`define PNPC_IX_ISOL     8'h01
`define PNPC_IX_CMD      8'h02
`define PNPC_IX_WAKE     8'h03
`define PNPC_IX_RES      8'h04
`define PNPC_IX_STAT     8'h05
`define PNPC_IX_CSN      8'h06
`define PNPC_IX_LDN      8'h07
`define PNPC_IX_BASEH    8'h60
`define PNPC_IX_BASEL    8'h61
`define PNPC_IX_DEVLO    8'h30
// -------------------------------------------------
// command bit positions and resets
// -------------------------------------------------
`define PNPC_CMD_RESET   0
`define PNPC_CMD_WFK     1
`define PNPC_CMD_CSNCLR  2
`define PNPC_KBC_DEV     6
`define PNPC_LDN_PP      8'h01
`define PNPC_RST_LDN     8'h00
`define PNPC_RST_CSN     8'h00
`define PNPC_RST_RDPORT  8'h00
// -------------------------------------------------
// bus addresses and protocol values
// -------------------------------------------------
`define PNPC_ADDR_KEYIX  12'h279
`define PNPC_ADDR_WDATA  12'hA79
`define PNPC_ADDR_MB0    12'h15C
`define PNPC_ADDR_MB1    12'h02E
`define PNPC_LFSR_SEED   8'h6A
`define PNPC_KEY_LEN     6'h20
`define PNPC_ISO_HI      8'h55
`define PNPC_ISO_LO      8'hAA
`define PNPC_END_TAG     8'h79
`define PNPC_ID_BITS     7'h48
`define PNPC_PP_HIGH     11'h400
`endif

// file: pnpc_config.v
// pnpc_config.v: pnp card control registers and parallel port decode.
// assumes isa pins arrive asynchronously; aen already qualified outside.
`include "pnpc_defines.vh"

module pnpc_config #(
    parameter [71:0] CARD_ID     = 72'h5A_0123_4567_89AB_CDEF, // arbitrary
    parameter [10:0] PP_BASE_RST = 11'h378
) (
    input  wire        clock,
    input  wire        rst,
    input  wire [11:0] isa_addr,
    input  wire        isa_aen,
    input  wire        isa_ior_n,
    input  wire        isa_iow_n,
    input  wire [7:0]  isa_data_in,
    output wire [7:0]  isa_data_out,
    output wire        isa_data_oe_n,
    input  wire        base_addr_strap_high,
    input  wire        base_addr_strap_sel,
    input  wire [3:0]  pp_mode_bits,
    output wire        pp_select,
    output wire [10:0] pp_offset,
    output reg  [7:0]  dev_reset,
    output reg  [7:0]  dev_wr_sel,
    output wire [7:0]  dev_index,
    output wire [7:0]  dev_wdata,
    input  wire [7:0]  dev_rdata,
    output wire [7:0]  logical_dev
);
    // -------------------------------------------------
    // card states
    // -------------------------------------------------
    // one-hot card states
    localparam [3:0] ST_WFK = 4'b0001;
    localparam [3:0] ST_SLP = 4'b0010;
    localparam [3:0] ST_ISO = 4'b0100;
    localparam [3:0] ST_CFG = 4'b1000;

    // -------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------
    // bit 24 a11, 23:22 straps, 21:19 strobes and aen, 18:11 data
    reg [24:0] s1_q;
    reg [24:0] s2_q;
    reg        ior_d_q;
    reg        iow_d_q;
    // two flops on every isa pin and strap before any use
    always @(posedge clock)
    begin
        s1_q <= {isa_addr[11], base_addr_strap_sel, base_addr_strap_high, isa_iow_n,
                 isa_ior_n, isa_aen, isa_data_in, isa_addr[10:0]};
        s2_q <= s1_q;
        ior_d_q <= s2_q[20];
        iow_d_q <= s2_q[21];
    end

    wire [10:0] a_s   = s2_q[10:0];
    wire [7:0]  din_s = s2_q[18:11];
    wire        aen_s = s2_q[19];
    wire        ior_s = s2_q[20];
    wire        iow_s = s2_q[21];
    wire        rd_go = ior_d_q & ~ior_s;  // read strobe fall
    wire        rd_end = ~ior_d_q & ior_s; // read strobe rise
    wire        wr_go = iow_d_q & ~iow_s;  // write strobe fall
    wire        a11_s = s2_q[24];
    // a11 tied low where folded into aen; when set it
    // leaves only the write-data port decoded
    wire        off_bus = aen_s | a11_s;

    // -------------------------------------------------
    // state registers
    // -------------------------------------------------
    // strap-latched mode and card registers
    reg        mb_q;
    reg        msel_q;
    reg [3:0]  st_q;
    reg [7:0]  ix_q;
    reg [7:0]  rdp_q;
    reg [7:0]  csn_q;
    reg [7:0]  ldn_q;
    reg [10:0] ppb_q;
    // key detector
    reg [7:0]  lfsr_q;
    reg [5:0]  keyc_q;
    // isolation progress
    reg [6:0]  idb_q;
    reg        half_q;
    reg        saw_q;
    // resource pointer and ready flag
    reg [4:0]  rptr_q;
    reg        rrdy_q;
    // read answer
    reg [7:0]  dout_q;
    reg        drv_q;

    // -------------------------------------------------
    // port address decode
    // -------------------------------------------------
    wire [11:0] a12   = {a11_s, a_s};
    wire [11:0] mbix  = msel_q ? `PNPC_ADDR_MB1 : `PNPC_ADDR_MB0;
    wire        key_a = ~off_bus & (a12 == `PNPC_ADDR_KEYIX);
    // only a11 tells the index port from the write-data port,
    // so an index write never lands as a data write
    wire        wd_a  = ~aen_s & (a12 == `PNPC_ADDR_WDATA);
    // read port lives in 003h-3FFh: a10 must be clear
    wire        rdp_a = ~off_bus & (a_s == {1'b0, rdp_q, 2'b11});
    wire        mix_a = ~off_bus & (a12 == mbix);
    wire        mdt_a = ~off_bus & (a12 == (mbix + 12'h001));
    wire        ix_wr  = mb_q ? mix_a : key_a;
    wire        dt_wr  = mb_q ? mdt_a : wd_a;
    wire        dt_rd  = mb_q ? mdt_a : (rdp_a & (st_q[2] | st_q[3]));
    wire        ix_rd  = mb_q & mix_a;

    // -------------------------------------------------
    // resource data and isolation helpers
    // -------------------------------------------------
    // part-select only used below byte 9
    wire [7:0] id_byte = CARD_ID[{rptr_q[3:0], 3'b000} +: 8];
    wire [7:0] res_b   = (rptr_q < 5'h09) ? id_byte :
                         (rptr_q == 5'h09) ? `PNPC_END_TAG : 8'h00;
    wire       id_bit  = CARD_ID[idb_q];
    // key sequence shift
    wire [7:0] lfsr_n  = {lfsr_q[0] ^ lfsr_q[1], lfsr_q[7:1]};

    // -------------------------------------------------
    // read mux for the data port
    // -------------------------------------------------
    reg [7:0] rmux;
    reg       rdrv;
    always @*
    begin
        rmux = 8'h00;
        rdrv = 1'b1;
        if (ix_q == `PNPC_IX_ISOL)
        begin
            // driven only for a one bit of the id
            rmux = half_q ? `PNPC_ISO_LO : `PNPC_ISO_HI;
            rdrv = st_q[2] & id_bit;
        end
        else if (ix_q == `PNPC_IX_RES)
            rmux = res_b;
        else if (ix_q == `PNPC_IX_STAT)
            rmux = {7'h00, rrdy_q};
        else if (ix_q == `PNPC_IX_CSN)
            rmux = csn_q;
        else if (ix_q == `PNPC_IX_LDN)
            rmux = ldn_q;
        else if (ix_q == `PNPC_IX_BASEH && ldn_q == `PNPC_LDN_PP)
            rmux = {5'b00000, ppb_q[10:8]};
        else if (ix_q == `PNPC_IX_BASEL && ldn_q == `PNPC_LDN_PP)
            rmux = ppb_q[7:0];
        else if (ix_q >= `PNPC_IX_DEVLO)
            rmux = dev_rdata;
        // write-only indexes 00h, 02h, 03h read as zero
    end

    // -------------------------------------------------
    // bus read answer
    // -------------------------------------------------
    // data captured at strobe fall, driven while strobe stays low
    always @(posedge clock)
    begin
        if (rst)
        begin
            dout_q <= 8'h00;
            drv_q  <= 1'b0;
        end
        else if (rd_go)
        begin
            dout_q <= ix_rd ? ix_q : rmux;
            drv_q  <= ix_rd | (dt_rd & rdrv & (st_q[2] | st_q[3]));
        end
        else if (ior_s)
            drv_q <= 1'b0;
    end
    // oe follows the synced strobe at once
    assign isa_data_out  = dout_q;
    assign isa_data_oe_n = ~(drv_q & ~ior_s);

    // -------------------------------------------------
    // card control state machine and registers
    // -------------------------------------------------
    // config-only writes vs anything but wait-for-key
    wire cfg_ok = st_q[3];
    wire cmd_ok = ~st_q[0];
    always @(posedge clock)
    begin
        // pulses last one cycle
        dev_reset  <= 8'h00;
        dev_wr_sel <= 8'h00;
        if (rst)
        begin
            // straps read through the synchronisers
            mb_q   <= s2_q[22];
            msel_q <= s2_q[23];
            st_q   <= s2_q[22] ? ST_CFG : ST_WFK;
            ix_q   <= 8'h00;
            rdp_q  <= `PNPC_RST_RDPORT;
            csn_q  <= `PNPC_RST_CSN;
            ldn_q  <= `PNPC_RST_LDN;
            ppb_q  <= PP_BASE_RST;
            lfsr_q <= `PNPC_LFSR_SEED;
            keyc_q <= 6'h00;
            idb_q  <= 7'h00;
            half_q <= 1'b0;
            saw_q  <= 1'b0;
            rptr_q <= 5'h00;
            rrdy_q <= 1'b1;
        end
        else
        begin
            // initiation key only counts in wait-for-key
            if (wr_go && key_a && !mb_q)
            begin
                if (st_q == ST_WFK && din_s == lfsr_q)
                begin
                    lfsr_q <= lfsr_n;
                    keyc_q <= keyc_q + 6'h01;
                    if (keyc_q == `PNPC_KEY_LEN - 6'h01)
                    begin
                        st_q   <= ST_SLP;
                        lfsr_q <= `PNPC_LFSR_SEED;
                        keyc_q <= 6'h00;
                    end
                end
                else
                begin
                    lfsr_q <= `PNPC_LFSR_SEED;
                    keyc_q <= 6'h00;
                end
            end
            // index follows each write to it
            if (wr_go && ix_wr)
                ix_q <= din_s;
            // data port writes
            if (wr_go && dt_wr && cmd_ok)
            begin
                if (ix_q == `PNPC_IX_RDPORT)
                    rdp_q <= din_s;
                else if (ix_q == `PNPC_IX_CMD)
                begin
                    if (din_s[`PNPC_CMD_RESET])
                    begin
                        ldn_q <= `PNPC_RST_LDN;
                        ppb_q <= PP_BASE_RST;
                        rdp_q <= `PNPC_RST_RDPORT;
                        dev_reset <= 8'hFF & ~(8'h01 << `PNPC_KBC_DEV);
                    end
                    if (din_s[`PNPC_CMD_WFK] && !mb_q)
                        st_q <= ST_WFK;
                    if (din_s[`PNPC_CMD_CSNCLR])
                        csn_q <= 8'h00;
                    // upper bits have no function
                end
                else if (ix_q == `PNPC_IX_WAKE)
                begin
                    rptr_q <= 5'h00;
                    rrdy_q <= 1'b1;
                    idb_q  <= 7'h00;
                    half_q <= 1'b0;
                    if (din_s == csn_q && st_q == ST_SLP)
                        st_q <= (din_s == 8'h00) ? ST_ISO : ST_CFG;
                    // another card named: sleep
                    else if (din_s != csn_q && !mb_q)
                        st_q <= ST_SLP;
                end
                else if (ix_q == `PNPC_IX_CSN && (cfg_ok || st_q[2]))
                begin
                    // numbered in isolation: go to config
                    csn_q <= din_s;
                    if (st_q[2])
                        st_q <= ST_CFG;
                end
                else if (ix_q == `PNPC_IX_LDN && cfg_ok)
                    ldn_q <= din_s;
                else if (ix_q == `PNPC_IX_BASEH && cfg_ok && ldn_q == `PNPC_LDN_PP)
                    ppb_q[10:8] <= din_s[2:0];
                else if (ix_q == `PNPC_IX_BASEL && cfg_ok && ldn_q == `PNPC_LDN_PP)
                    ppb_q[7:0] <= din_s;
                else if (ix_q >= `PNPC_IX_DEVLO && cfg_ok)
                    dev_wr_sel <= 8'h01 << ldn_q[2:0];
                // 01h, 04h, 05h and 08h-2Fh are read-only here
            end
            // resource byte consumed: ready again after one cycle
            if (rd_go && dt_rd && cfg_ok && ix_q == `PNPC_IX_RES && rrdy_q)
            begin
                rrdy_q <= 1'b0;
                rptr_q <= rptr_q + 5'h01;
            end
            else if (!rrdy_q)
                rrdy_q <= 1'b1;
            // isolation: pair of reads per id bit, others' bus sampled at end
            if (rd_end && dt_rd && st_q[2] && ix_q == `PNPC_IX_ISOL)
            begin
                half_q <= ~half_q;
                if (!half_q)
                    saw_q <= (din_s == `PNPC_ISO_HI);
                else
                begin
                    if (!id_bit && saw_q && din_s == `PNPC_ISO_LO)
                        st_q <= ST_SLP;
                    if (idb_q != `PNPC_ID_BITS - 7'h01)
                        idb_q <= idb_q + 7'h01;
                end
            end
        end
    end

    // -------------------------------------------------
    // parallel port range decode
    // -------------------------------------------------
    wire        spp   = ~pp_mode_bits[3] & ~pp_mode_bits[2];
    wire        epp   = ~pp_mode_bits[3] &  pp_mode_bits[2];
    // base aligned to 4 in spp, else to 8
    wire [10:0] abase = spp ? {ppb_q[10:2], 2'b00}
                            : {ppb_q[10:3], 3'b000};
    // offsets below base wrap out of every range while base is below 400h
    wire [10:0] off   = a_s - abase;
    wire        lo8   = (off < 11'h008);
    wire        lo3   = (off < 11'h003);
    wire        hi3   = (off >= `PNPC_PP_HIGH) && (off < `PNPC_PP_HIGH + 11'h003);
    wire        hi8   = (off >= `PNPC_PP_HIGH) && (off < `PNPC_PP_HIGH + 11'h008);
    reg         pp_hit;
    // range chosen by mode bits 7:4
    // 1010 and 1100 decode nothing
    always @*
    begin
        pp_hit = 1'b0;
        if (spp)
            pp_hit = lo3;
        else if (epp)
            pp_hit = lo8;
        else if (pp_mode_bits[0])
            pp_hit = lo8 | hi8;
        else if (pp_mode_bits[2:1] == 2'b11)
            pp_hit = lo8 | hi3;
        else if (pp_mode_bits[2:1] == 2'b00)
            pp_hit = lo3 | hi3;
    end
    assign pp_select   = pp_hit & ~off_bus;
    assign pp_offset   = off;
    assign dev_index   = ix_q;
    assign dev_wdata   = din_s;
    assign logical_dev = ldn_q;
endmodule // pnpc_config

// file: pnpc_config_properties.sv
// pnpc_config_properties.sv: timing and decode checks on pnpc_config ports.
// assumes one clock domain and the synchronous active-high rst.
module pnpc_config_properties (
    input logic        clock,
    input logic        rst,
    input logic        isa_aen,
    input logic        isa_ior_n,
    input logic        isa_data_oe_n,
    input logic [3:0]  pp_mode_bits,
    input logic        pp_select,
    input logic [10:0] pp_offset,
    input logic [7:0]  dev_reset,
    input logic [7:0]  dev_wr_sel,
    input logic [7:0]  logical_dev
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dflt @(posedge clock);
    endclocking
    default disable iff (rst);
    // -------------------------------------------------
    // bus, command and decode relations
    // -------------------------------------------------
    a_reset_quiet:
        assert property (disable iff (1'b0) rst |=> isa_data_oe_n && dev_reset == 8'h00
            && dev_wr_sel == 8'h00 && logical_dev == 8'h00) else $error("outputs busy after reset");
    a_oe_needs_read:
        assert property ($fell(isa_data_oe_n) |-> !isa_ior_n && $past(isa_ior_n, 2) == 1'b0)
        else $error("data driven without a read");
    a_oe_release:
        assert property (isa_ior_n [*4] |-> isa_data_oe_n) else $error("data held after read");
    a_kbc_kept:
        assert property (dev_reset[6] == 1'b0) else $error("keyboard unit reset");
    a_cmd_pulse:
        assert property (dev_reset != 8'h00 |=> dev_reset == 8'h00) else $error("reset pulse sticks");
    a_wr_sel_ldn:
        assert property (dev_wr_sel != 8'h00 |-> dev_wr_sel == (8'h01 << logical_dev[2:0])
            ##1 dev_wr_sel == 8'h00) else $error("write select off target");
    a_aen_blocks:
        assert property (isa_aen [*4] |-> !pp_select) else $error("select with aen high");
    a_spp_span:
        assert property (pp_select && pp_mode_bits[3:2] == 2'b00 |-> pp_offset <= 11'h002)
        else $error("spp range exceeded");
    a_epp_span:
        assert property (pp_select && pp_mode_bits[3:2] == 2'b01 |-> pp_offset <= 11'h007)
        else $error("epp range exceeded");
    a_six_span:
        assert property (pp_select && pp_mode_bits == 4'h8 |-> pp_offset <= 11'h002
            || (pp_offset >= 11'h400 && pp_offset <= 11'h402)) else $error("six range exceeded");
    a_eleven_span:
        assert property (pp_select && pp_mode_bits == 4'hE |-> pp_offset <= 11'h007
            || (pp_offset >= 11'h400 && pp_offset <= 11'h402)) else $error("eleven range exceeded");
    a_high_span:
        assert property (pp_select |-> pp_offset[9:3] == 7'h00) else $error("offset outside groups");
endmodule // pnpc_config_properties

bind pnpc_config pnpc_config_properties i_props (
    .clock(clock), .rst(rst), .isa_aen(isa_aen), .isa_ior_n(isa_ior_n), .isa_data_oe_n(isa_data_oe_n),
    .pp_mode_bits(pp_mode_bits), .pp_select(pp_select), .pp_offset(pp_offset), .dev_reset(dev_reset),
    .dev_wr_sel(dev_wr_sel), .logical_dev(logical_dev)
);

// file: pnpc_isa_host.sv
// pnpc_isa_host.sv: isa host bus model run by configuration software.
// assumes one clock; pins change 1 ns after the rising edge.
module pnpc_isa_host (
    input  logic        clock,
    input  logic        full_ir,
    output logic [11:0] isa_addr,
    output logic        isa_aen,
    output logic        isa_ior_n,
    output logic        isa_iow_n,
    output logic [7:0]  isa_data_in,
    input  logic [7:0]  isa_data_out,
    input  logic        isa_data_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] addr16;
    logic        drv;
    logic [7:0]  wdat;
    // two-uart folds a15-11 into aen, full-ir a15-12 with a11 on its pin
    assign isa_addr = addr16[11:0];
    assign isa_aen = full_ir ? |addr16[15:12] : |addr16[15:11];
    // bus level: device, host, else pull-up
    assign isa_data_in = !isa_data_oe_n ? isa_data_out : (drv ? wdat : 8'hFF);
    initial
    begin
        addr16 = 16'h0000;
        drv = 1'b0;
        wdat = 8'h00;
        isa_ior_n = 1'b1;
        isa_iow_n = 1'b1;
    end
    // -------------------------------------------------
    // one strobe cycle with setup, hold and recovery
    // -------------------------------------------------
    task automatic cycle(input logic [15:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        #1;
        addr16 = a;
        wdat = d;
        drv = wr;
        repeat (4) @(posedge clock);
        #1;
        isa_iow_n = !wr;
        isa_ior_n = wr;
        repeat (6) @(posedge clock);
        q = isa_data_in;
        #1;
        isa_iow_n = 1'b1;
        isa_ior_n = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        drv = 1'b0;
    endtask
    // address only, no strobe; returns off the edge
    task automatic park(input logic [15:0] a);
        @(posedge clock);
        #1;
        addr16 = a;
        repeat (4) @(posedge clock);
        #2;
    endtask
endmodule // pnpc_isa_host

// file: pnpc_config_tb_top.sv
// pnpc_config_tb_top.sv: self-checking bench for pnpc_config.
// assumes motherboard strap until t_pnp_key, index/data at 15Ch/15Dh.
module pnpc_config_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] IX = 16'h015C;
    localparam logic [15:0] DT = 16'h015D;
    localparam logic [71:0] ID = 72'h11_2233_4455_6677_8899; // arbitrary board id
    logic        clock;
    logic        rst;
    logic [3:0]  mode;
    logic [7:0]  dev_rdata;
    logic        strap_high;
    logic        strap_sel;
    logic        full_ir;
    wire  [11:0] isa_addr;
    wire  [7:0]  isa_data_in;
    wire  [7:0]  isa_data_out;
    wire  [10:0] pp_offset;
    wire  [7:0]  dev_reset;
    wire  [7:0]  dev_wr_sel;
    wire  [7:0]  logical_dev;
    wire         isa_aen;
    wire         isa_ior_n;
    wire         isa_iow_n;
    wire         isa_data_oe_n;
    wire         pp_select;
    int          n_fail = 0;
    int          checks = 0;
    pnpc_config #(.CARD_ID(ID)) i_dut (
        .clock(clock), .rst(rst), .isa_addr(isa_addr), .isa_aen(isa_aen), .isa_ior_n(isa_ior_n),
        .isa_iow_n(isa_iow_n), .isa_data_in(isa_data_in), .isa_data_out(isa_data_out),
        .isa_data_oe_n(isa_data_oe_n), .base_addr_strap_high(strap_high), .base_addr_strap_sel(strap_sel),
        .pp_mode_bits(mode), .pp_select(pp_select), .pp_offset(pp_offset), .dev_reset(dev_reset),
        .dev_wr_sel(dev_wr_sel), .dev_index(), .dev_wdata(), .dev_rdata(dev_rdata), .logical_dev(logical_dev)
    );
    pnpc_isa_host i_host (
        .clock(clock), .full_ir(full_ir),
        .isa_addr(isa_addr), .isa_aen(isa_aen), .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n),
        .isa_data_in(isa_data_in), .isa_data_out(isa_data_out), .isa_data_oe_n(isa_data_oe_n)
    );
    // -------------------------------------------------
    // shared helpers
    // -------------------------------------------------
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        logic [7:0] q;
        i_host.cycle(IX, 1'b1, ix, q);
        i_host.cycle(DT, 1'b1, d, q);
    endtask
    task automatic pwr(input logic [7:0] ix, input logic [7:0] d);
        logic [7:0] q;
        i_host.cycle(16'h0279, 1'b1, ix, q);
        i_host.cycle(16'h0A79, 1'b1, d, q);
    endtask
    task automatic rdchk(input logic [7:0] ix, input logic [7:0] exp, input string what);
        logic [7:0] q;
        i_host.cycle(IX, 1'b1, ix, q);
        i_host.cycle(DT, 1'b0, 8'h00, q);
        chk(what, {3'b000, exp}, {3'b000, q});
    endtask
    // expected parallel select for a mode and an offset from base
    function automatic logic exp_sel(input logic [3:0] m, input logic [11:0] o);
        logic lo3, lo8, hi3, hi8;
        lo3 = o < 12'h003;
        lo8 = o < 12'h008;
        hi3 = o >= 12'h400 && o < 12'h403;
        hi8 = o >= 12'h400 && o < 12'h408;
        if (m[3] == 1'b0)
            return m[2] ? lo8 : lo3;
        if (m[0])
            return lo8 | hi8;
        return (m == 4'h8) ? (lo3 | hi3) : ((m == 4'hE) ? (lo8 | hi3) : 1'b0);
    endfunction
    task automatic report_and_stop;
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // -------------------------------------------------
    // scenarios
    // -------------------------------------------------
    task automatic t_control_regs;
        logic [7:0] q;
        rdchk(8'h07, 8'h00, "ldn after reset");
        wr(8'h07, 8'h01);
        i_host.cycle(IX, 1'b0, 8'h00, q);
        chk("index port", 11'h007, {3'b000, q});
        rdchk(8'h07, 8'h01, "ldn");
        chk("logical_dev", 11'h001, {3'b000, logical_dev});
        wr(8'h06, 8'h5A);
        rdchk(8'h06, 8'h5A, "csn");
        wr(8'h02, 8'hF8);
        rdchk(8'h06, 8'h5A, "csn after upper command bits");
        wr(8'h02, 8'h04);
        rdchk(8'h06, 8'h00, "csn cleared");
        rdchk(8'h02, 8'h00, "command readback");
    endtask
    task automatic t_soft_reset;
        wr(8'h06, 8'h33);
        wr(8'h07, 8'h03);
        wr(8'h02, 8'h02);
        rdchk(8'h07, 8'h03, "ldn after wait-for-key command");
        wr(8'h02, 8'h01);
        rdchk(8'h06, 8'h33, "csn kept");
        rdchk(8'h07, 8'h00, "ldn default");
    endtask
    task automatic t_device_regs;
        wr(8'h07, 8'h01);
        wr(8'h30, 8'hA5);
        dev_rdata = 8'h3C;
        rdchk(8'h30, 8'h3C, "device data");
        wr(8'h60, 8'hFB);
        rdchk(8'h60, 8'h03, "base high");
        wr(8'h61, 8'h7C);
        mode = 4'h9;
        i_host.park(16'h0378);
        chk("aligned select", 11'h001, {10'h000, pp_select});
        chk("aligned offset", 11'h000, pp_offset);
        wr(8'h61, 8'h78);
    endtask
    task automatic t_resource;
        rdchk(8'h05, 8'h01, "status ready");
        rdchk(8'h04, ID[7:0], "resource byte 0");
        rdchk(8'h05, 8'h01, "status ready again");
        rdchk(8'h04, ID[15:8], "resource byte 1");
    endtask
    task automatic t_pnp_key;
        logic [7:0] q;
        logic [7:0] k;
        @(posedge clock);
        #1;
        rst = 1'b1;
        strap_high = 1'b0;
        full_ir = 1'b1;
        repeat (12) @(posedge clock);
        #1;
        rst = 1'b0;
        wr(8'h07, 8'h05);
        chk("ldn in wait-for-key", 11'h000, {3'b000, logical_dev});
        k = 8'h6A;
        repeat (32)
        begin
            i_host.cycle(16'h0279, 1'b1, k, q);
            k = {k[0] ^ k[1], k[7:1]};
        end
        pwr(8'h03, 8'h00);
        pwr(8'h06, 8'h07);
        pwr(8'h07, 8'h02);
        chk("ldn after wake", 11'h002, {3'b000, logical_dev});
        pwr(8'h00, 8'h80);
        i_host.cycle(16'h0279, 1'b1, 8'h07, q);
        i_host.cycle(16'h0203, 1'b0, 8'h00, q);
        chk("read port data", 11'h002, {3'b000, q});
    endtask
    task automatic t_pp_decode;
        logic [11:0] addrs [11] = '{12'h377, 12'h378, 12'h37A, 12'h37B, 12'h37F, 12'h380,
                                    12'h778, 12'h77A, 12'h77B, 12'h77F, 12'h780};
        logic [3:0]  modes [6] = '{4'h0, 4'h4, 4'h8, 4'hE, 4'h9, 4'hA};
        foreach (modes[m])
        begin
            i_host.park(16'h0000);
            mode = modes[m];
            foreach (addrs[k])
            begin
                i_host.park({4'h0, addrs[k]});
                chk("pp_select", {10'h000, exp_sel(modes[m], addrs[k] - 12'h378)}, {10'h000, pp_select});
            end
        end
    endtask
    task automatic t_aen;
        mode = 4'h9;
        i_host.park(16'h8378);
        chk("upper address select", 11'h000, {10'h000, pp_select});
        full_ir = 1'b1;
        i_host.park(16'h1378);
        chk("full-ir upper select", 11'h000, {10'h000, pp_select});
        i_host.park(16'h0378);
        chk("lower address select", 11'h001, {10'h000, pp_select});
    endtask
    // -------------------------------------------------
    // clock, sequence and watchdog
    // -------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial
    begin
        rst = 1'b1;
        mode = 4'h0;
        dev_rdata = 8'h00;
        strap_high = 1'b1;
        strap_sel = 1'b0;
        full_ir = 1'b0;
        repeat (12) @(posedge clock);
        #1;
        rst = 1'b0;
        t_control_regs();
        t_soft_reset();
        t_device_regs();
        t_resource();
        t_pp_decode();
        t_aen();
        t_pnp_key();
        report_and_stop();
    end
    initial
    begin
        repeat (30000) @(posedge clock);
        n_fail++;
        report_and_stop();
    end
endmodule // pnpc_config_tb_top
